// File: rtl/sun_angle_pkg.sv
// Shared constants and carrier types for the sun-angle readout
package sun_angle_pkg;
    localparam int STAGE_COUNT = 8;
    localparam int ANGLE_BITS = 7;
    localparam int MARKER_POS = 7;
    localparam int FIRST_ANGLE_POS = 0;
    localparam logic [7:0] STAGES_RESET = 8'h00;
    localparam int CLK_HZ = 50000000;
    localparam int SHIFT_PERIOD_MS = 375;
    // Pulse period in clock cycles, rounded down
    localparam int SHIFT_PERIOD_CYCLES = (CLK_HZ / 1000) * SHIFT_PERIOD_MS;
    // Return-to-bias pulse width is half a shift period
    localparam int PULSE_HIGH_CYCLES = SHIFT_PERIOD_CYCLES / 2;
    localparam int FIFO_DEPTH = 8;
    // Sun angle at code zero and step, in tenths of a degree
    localparam int ANGLE_BASE_DECI = 265;
    localparam int ANGLE_STEP_DECI = 10;
    localparam int ANGLE_TOP_DECI = 1535;

    typedef struct packed {
        logic [6:0] gray;
        logic [6:0] binary;
    } angle_word_t;
endpackage

// File: rtl/word_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
module word_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Fill side
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // Drain side
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH)
    begin
        $error("word_fifo depth must be a power of two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_reg;
    logic [AW:0] rd_reg;
    logic do_wr;
    logic do_rd;

    assign in_ready = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
    assign out_valid = wr_reg != rd_reg;
    assign out_data = mem[rd_reg[AW-1:0]];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;

    always_ff @(posedge clk)
    begin
        if (do_wr)
            mem[wr_reg[AW-1:0]] <= in_data;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            wr_reg <= '0;
        else if (do_wr)
            wr_reg <= wr_reg + 1'b1;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            rd_reg <= '0;
        else if (do_rd)
            rd_reg <= rd_reg + 1'b1;
    end
endmodule

// File: rtl/sun_angle_gray_serializer.sv
// Sun-angle readout: trigger-edge load, 8-stage shift, return-to-bias output
// How it works
// (RULE_01) Reset clears all eight stages
// (RULE_02) Stages all clear keeps shift oscillator stopped; the code also keeps it running while word_reg holds unsent bits
// (RULE_03) Load only on trigger falling edge
// (RULE_04) Load sets marker and lit angle stages
// (RULE_05) Marker set starts the shift oscillator
// (RULE_06) First shift clears marker; 375 ms spacing
// (RULE_07) Output gates data with oscillator pulse
// (RULE_08) Eight shifts clear stages, stop oscillator
// (RULE_09) Idle until next trigger trailing edge
// (RULE_10) Seven angle bits are reflected Gray code
// (RULE_11) Eighth bit is always-one end marker
// (RULE_12) Command cell signal acts as trigger
// (RULE_13) Trigger during readout is ignored
// (RULE_14) Shift period from parameterised clock divider
module sun_angle_gray_serializer #(
    parameter int SHIFT_PERIOD_CYCLES = sun_angle_pkg::SHIFT_PERIOD_CYCLES,
    parameter int PULSE_HIGH_CYCLES = sun_angle_pkg::PULSE_HIGH_CYCLES,
    parameter int FIFO_DEPTH = sun_angle_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Sensor inputs (asynchronous)
    input wire logic command_cell,
    input wire logic [6:0] angle_cells,
    // Telemetry output
    output logic telemetry_out,
    output logic readout_busy,
    // Captured angle words
    output logic [6:0] angle_gray,
    output logic [6:0] angle_binary,
    output logic angle_valid,
    input wire logic angle_ready,
    output logic capture_dropped
);
    localparam int PW = 32;

    // Elaboration checks on what the counters can serve
    if (SHIFT_PERIOD_CYCLES < 2)
    begin
        $error("shift period too short");
    end

    if (PULSE_HIGH_CYCLES < 1 || PULSE_HIGH_CYCLES >= SHIFT_PERIOD_CYCLES)
    begin
        $error("pulse width must be shorter than the shift period");
    end

    if (FIFO_DEPTH < 2)
    begin
        $error("capture FIFO too shallow");
    end

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_SHIFT = 3'b100
    } state_t;

    // Gray to binary conversion, bit 0 is first (least significant) stage
    function automatic logic [6:0] gray_to_bin(input logic [6:0] g);
        logic [6:0] b;
        b = '0;
        b[6] = g[6];
        for (int i = 5; i >= 0; i--)
            b[i] = b[i+1] ^ g[i];
        return b;
    endfunction

    // True while any stage of a register still holds a one
    function automatic logic any_set(input logic [7:0] s);
        return s != sun_angle_pkg::STAGES_RESET;
    endfunction

    // True on the shift that carries the last bit out
    function automatic logic last_shift(input logic [3:0] cnt);
        return cnt == 4'(sun_angle_pkg::STAGE_COUNT - 1);
    endfunction

    // True while a readout is under way
    function automatic logic in_readout(input state_t s);
        return s != ST_IDLE;
    endfunction

    // Synchronisers
    logic cmd_meta_reg;
    logic cmd_sync_reg;
    logic cmd_prev_reg;
    logic [6:0] cells_meta_reg;
    logic [6:0] cells_sync_reg;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cmd_meta_reg <= 1'b0;
            cmd_sync_reg <= 1'b0;
            cmd_prev_reg <= 1'b0;
        end
        else
        begin
            cmd_meta_reg <= command_cell;
            cmd_sync_reg <= cmd_meta_reg;
            cmd_prev_reg <= cmd_sync_reg;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cells_meta_reg <= '0;
            cells_sync_reg <= '0;
        end
        else
        begin
            cells_meta_reg <= angle_cells;
            cells_sync_reg <= cells_meta_reg;
        end
    end

    logic trig_fall;
    assign trig_fall = cmd_prev_reg && !cmd_sync_reg; // RULE_03 RULE_12

    state_t state_reg;
    logic [7:0] stages_reg;
    logic [PW-1:0] div_reg;
    logic [3:0] shift_cnt_reg;
    logic [7:0] word_reg;
    logic [PW-1:0] pulse_cnt_reg;
    logic osc_run;
    logic shift_tick;
    logic load;

    // Oscillator runs while any stage or any unsent output bit is set,
    // so a word with few lit cells still gets all eight shifts
    assign osc_run = any_set(stages_reg) || any_set(word_reg); // RULE_02 RULE_05
    assign shift_tick = osc_run && (div_reg == PW'(SHIFT_PERIOD_CYCLES - 1)); // RULE_14
    assign load = trig_fall && (state_reg == ST_IDLE); // RULE_13 RULE_09

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            state_reg <= ST_IDLE;
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    if (load)
                        state_reg <= ST_WAIT;
                end
                ST_WAIT:
                begin
                    if (shift_tick)
                        state_reg <= ST_SHIFT;
                end
                ST_SHIFT:
                begin
                    if (shift_tick && last_shift(shift_cnt_reg))
                        state_reg <= ST_IDLE; // RULE_08
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    // Oscillator divider; stopped and cleared while inhibited
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            div_reg <= '0;
        else if (!osc_run || shift_tick)
            div_reg <= '0; // RULE_02
        else
            div_reg <= div_reg + 1'b1; // RULE_06 RULE_14
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            shift_cnt_reg <= '0;
        else if (load)
            shift_cnt_reg <= '0;
        else if (shift_tick)
            shift_cnt_reg <= shift_cnt_reg + 1'b1;
    end

    // Shift register: stage 0 is first_angle_stage, stage 7 marker_stage
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            stages_reg <= sun_angle_pkg::STAGES_RESET; // RULE_01
        else if (load)
            stages_reg <= {1'b1, cells_sync_reg}; // RULE_04 RULE_11 RULE_10
        else if (shift_tick && state_reg == ST_WAIT)
            stages_reg <= {1'b0, stages_reg[6:0]}; // RULE_06
        else if (shift_tick && state_reg == ST_SHIFT)
        begin
            if (last_shift(shift_cnt_reg))
                stages_reg <= sun_angle_pkg::STAGES_RESET; // RULE_08
            else
                stages_reg <= {1'b0, stages_reg[7:1]};
        end
    end

    // Serial bit: first shift starts with the first angle stage, eighth is the marker
    logic serial_bit;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            word_reg <= '0;
        else if (load)
            word_reg <= {1'b1, cells_sync_reg}; // RULE_11
        else if (shift_tick && in_readout(state_reg))
            word_reg <= {1'b0, word_reg[7:1]};
    end
    assign serial_bit = word_reg[sun_angle_pkg::FIRST_ANGLE_POS];

    // Return-to-bias pulse: high for a fixed width after the shift of a one bit
    logic rb_active_reg;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            rb_active_reg <= 1'b0;
        else if (shift_tick)
            rb_active_reg <= serial_bit && in_readout(state_reg);
        else if (pulse_cnt_reg == PW'(PULSE_HIGH_CYCLES - 1))
            rb_active_reg <= 1'b0;
    end

    // Width counter of its own: the marker pulse outlasts the oscillator
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            pulse_cnt_reg <= '0;
        else if (shift_tick || !rb_active_reg)
            pulse_cnt_reg <= '0;
        else
            pulse_cnt_reg <= pulse_cnt_reg + 1'b1;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            telemetry_out <= 1'b0;
        else
            telemetry_out <= rb_active_reg; // RULE_07
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            readout_busy <= 1'b0;
        else
            readout_busy <= in_readout(state_reg) || load;
    end

    // Captured words go to a FIFO; a full FIFO drops the word and flags it
    sun_angle_pkg::angle_word_t cap_word;
    sun_angle_pkg::angle_word_t out_word;
    logic fifo_in_ready;
    logic fifo_out_valid;
    assign cap_word.gray = cells_sync_reg;
    assign cap_word.binary = gray_to_bin(cells_sync_reg); // RULE_10

    word_fifo #(
        .WIDTH($bits(sun_angle_pkg::angle_word_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .resetn(resetn),
        .in_data(cap_word),
        .in_valid(load),
        .in_ready(fifo_in_ready),
        .out_data(out_word),
        .out_valid(fifo_out_valid),
        .out_ready(angle_ready && !angle_valid)
    );

    // Output register stage so every output comes from a flip-flop
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            angle_valid <= 1'b0;
            angle_gray <= '0;
            angle_binary <= '0;
        end
        else if (!angle_valid && fifo_out_valid && angle_ready)
        begin
            angle_valid <= 1'b1;
            angle_gray <= out_word.gray;
            angle_binary <= out_word.binary;
        end
        else if (angle_valid && angle_ready)
            angle_valid <= 1'b0;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            capture_dropped <= 1'b0;
        else
            capture_dropped <= load && !fifo_in_ready;
    end
endmodule

// File: test/sun_angle_monitor.sv
// Port checker for the sun-angle readout
module sun_angle_monitor #(
    parameter int SHIFT_PERIOD_CYCLES = 20,
    parameter int PULSE_HIGH_CYCLES = 10,
    parameter int FIFO_DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Sensor side
    input wire logic command_cell,
    input wire logic [6:0] angle_cells,
    // Outputs and consumer
    input wire logic telemetry_out,
    input wire logic readout_busy,
    input wire logic [6:0] angle_gray,
    input wire logic [6:0] angle_binary,
    input wire logic angle_valid,
    input wire logic angle_ready,
    input wire logic capture_dropped
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    int idle_reg;
    int busy_reg;
    int high_reg;
    int gap_reg;
    function automatic logic [6:0] to_bin(input logic [6:0] g);
        for (int i = 0; i < 7; i++) to_bin[i] = ^(g >> i);
    endfunction
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            idle_reg <= 0;
            busy_reg <= 0;
            high_reg <= 0;
            gap_reg <= 0;
        end
        else
        begin
            idle_reg <= readout_busy ? 0 : idle_reg + (idle_reg < 999);
            busy_reg <= readout_busy ? busy_reg + 1 : 0;
            high_reg <= telemetry_out ? high_reg + 1 : 0;
            gap_reg <= $rose(readout_busy) ? 0 : $rose(telemetry_out) ? 1 : gap_reg + (gap_reg != 0);
        end
    end
    sequence s_idle_fall;
        $fell(command_cell) && idle_reg > 4;
    endsequence
    sequence s_rise_held;
        $rose(command_cell) && idle_reg > 4 ##1 command_cell [*6];
    endsequence
    a_fall_loads: assert property (s_idle_fall |-> ##[1:5] readout_busy [*4])
        else $error("no readout after trigger fall");
    a_rise_ignored: assert property (s_rise_held |-> !readout_busy)
        else $error("readout on trigger rise");
    a_idle_quiet: assert property (idle_reg > PULSE_HIGH_CYCLES + 3 |-> !telemetry_out)
        else $error("pulse while idle");
    a_busy_span: assert property ($fell(readout_busy) |-> busy_reg == 8 * SHIFT_PERIOD_CYCLES + 1)
        else $error("readout length wrong");
    a_pulse_width: assert property ($fell(telemetry_out) |-> high_reg == PULSE_HIGH_CYCLES)
        else $error("pulse width wrong");
    a_pulse_grid: assert property ($rose(telemetry_out) && gap_reg != 0 |->
        gap_reg % SHIFT_PERIOD_CYCLES == 0)
        else $error("pulse off shift grid");
    a_drop_pulse: assert property (capture_dropped |-> readout_busy ##1 !capture_dropped)
        else $error("drop flag wrong");
    a_gray_binary: assert property (angle_valid |-> angle_binary == to_bin(angle_gray))
        else $error("binary does not match gray");
    a_word_holds: assert property (angle_valid && !angle_ready |=> angle_valid && $stable(angle_gray))
        else $error("offered word changed");
endmodule
bind sun_angle_gray_serializer sun_angle_monitor #(.SHIFT_PERIOD_CYCLES(SHIFT_PERIOD_CYCLES),
    .PULSE_HIGH_CYCLES(PULSE_HIGH_CYCLES), .FIFO_DEPTH(FIFO_DEPTH)) mon (.clk, .resetn, .command_cell,
    .angle_cells, .telemetry_out, .readout_busy, .angle_gray, .angle_binary, .angle_valid, .angle_ready,
    .capture_dropped);

// File: test/telemetry_sink.sv
// Telemetry receiver and word consumer model
module telemetry_sink (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Device side
    input wire logic telemetry_out,
    output logic angle_ready,
    // Bench control
    input wire logic stall,
    output int pulses
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_reg;
    assign angle_ready = !stall;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            last_reg <= 1'h0;
            pulses <= 0;
        end
        else
        begin
            last_reg <= telemetry_out;
            pulses <= pulses + (telemetry_out && !last_reg);
        end
    end
endmodule

// File: test/tb.sv
// Self-checking bench for the sun-angle readout
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SP = 20;
    localparam int PH = 10;
    logic clk = 1'h0;
    logic resetn = 1'h0;
    logic command_cell = 1'h0;
    logic [6:0] angle_cells = 7'h00;
    logic stall = 1'h1;
    logic telemetry_out, readout_busy, angle_valid, angle_ready, capture_dropped;
    logic [6:0] angle_gray, angle_binary;
    logic [31:0] lfsr = 32'heb4c;
    logic [6:0] words[$];
    int pulses, mismatches, comparisons, cycles, drops;
    always #10 clk = ~clk;
    sun_angle_gray_serializer #(.SHIFT_PERIOD_CYCLES(SP), .PULSE_HIGH_CYCLES(PH), .FIFO_DEPTH(8)) dut (.clk,
        .resetn, .command_cell, .angle_cells, .telemetry_out, .readout_busy, .angle_gray, .angle_binary,
        .angle_valid, .angle_ready, .capture_dropped);
    telemetry_sink sink (.clk, .resetn, .telemetry_out, .angle_ready, .stall, .pulses);
    function automatic logic [6:0] bin(input logic [6:0] g);
        for (int i = 0; i < 7; i++) bin[i] = ^(g >> i);
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic tally_and_finish;
        if (mismatches == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // One trigger cycle, with a second trigger landing mid-readout
    task automatic readout(input logic [6:0] g);
        int p0;
        int n;
        angle_cells = g;
        step(4);
        command_cell = 1'h1;
        step(8);
        check("busy on rise", readout_busy, 1'h0);
        p0 = pulses;
        command_cell = 1'h0;
        for (n = 0; n < 8 && readout_busy !== 1'h1; n++) step(1);
        check("busy after fall", readout_busy, 1'h1);
        step(5);
        command_cell = 1'h1;
        step(4);
        command_cell = 1'h0;
        angle_cells = ~g;
        step(SP + PH / 2 - 8);
        for (n = 1; n <= 8; n++)
        begin
            check("serial bit", telemetry_out, (n == 8) ? 1'h1 : g[n-1]);
            if (n < 8) step(SP);
        end
        for (n = 0; n < 10 * SP && readout_busy === 1'h1; n++) step(1);
        check("busy end", readout_busy, 1'h0);
        step(PH + 8);
        check("stays idle", readout_busy, 1'h0);
        check("pulse count", pulses - p0, $countones(g) + 1);
        words.push_back(g);
    endtask
    always @(posedge clk)
    begin
        cycles++;
        drops += (capture_dropped === 1'h1);
        if (cycles == 20000)
        begin
            mismatches++;
            tally_and_finish();
        end
    end
    initial
    begin
        int n;
        step(6);
        resetn = 1'h1;
        check("reset outs", {telemetry_out, readout_busy, angle_valid, capture_dropped}, 4'h0);
        step(4);
        readout(7'h00);
        readout(7'h40);
        for (int i = 0; i < 7; i++)
        begin
            lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
            readout(lfsr[6:0]);
        end
        check("drops", drops, 1);
        void'(words.pop_back());
        stall = 1'h0;
        while (words.size() > 0)
        begin
            for (n = 0; n < 8 && angle_valid !== 1'h1; n++) step(1);
            stall = 1'h1;
            step(2);
            check("held", angle_valid, 1'h1);
            check("gray", angle_gray, words[0]);
            check("binary", angle_binary, bin(words.pop_front()));
            stall = 1'h0;
            step(1);
        end
        check("empty", angle_valid, 1'h0);
        // Power-on reset in the middle of a readout
        angle_cells = 7'h7f;
        command_cell = 1'h1;
        step(4);
        command_cell = 1'h0;
        step(2 * SP);
        resetn = 1'h0;
        step(2);
        check("reset mid", {telemetry_out, readout_busy, angle_valid, capture_dropped}, 4'h0);
        resetn = 1'h1;
        step(10 * SP);
        check("busy after reset", readout_busy, 1'h0);
        check("pulses after reset", pulses, 0);
        tally_and_finish();
    end
endmodule
